// >>> common/hpcfg_pkg.sv
package hpcfg_pkg;
    localparam logic [7:0] BOOST_OFS     = 8'hF8;
    localparam logic [7:0] SWAP_OFS      = 8'hFA;
    localparam logic [7:0] MAP_OFS       = 8'hFB;
    localparam logic [7:0] BOOST_RST     = 8'h00;
    localparam logic [7:0] SWAP_RST      = 8'h00;
    localparam logic [7:0] MAP_RST       = 8'h21;
    localparam logic [7:0] RDATA_RST     = 8'h00;
    localparam logic [1:0] LNUM1_RST     = 2'h1;
    localparam logic [1:0] LNUM2_RST     = 2'h2;
    localparam logic [1:0] COUNT_RST     = 2'h2;
    localparam logic [7:0] BOOST_MASK    = 8'h77;
    localparam logic [7:0] SWAP_MASK     = 8'h0E;
    localparam int         BOOST2_LSB    = 4;
    localparam int         BOOST1_LSB    = 0;
    localparam int         SWAP_LSB      = 1;
    localparam int         MAP2_LSB      = 4;
    localparam int         MAP1_LSB      = 0;
    localparam logic [3:0] MAP_MAX_CODE  = 4'h3;
    localparam logic [1:0] LOGIC_OFF     = 2'h0;
    typedef logic [2:0] hpcfg_boost_type;
    typedef logic [1:0] hpcfg_lnum_type;
endpackage

// >>> common/hpcfg_map_if.sv
interface hpcfg_map_if;
    import hpcfg_pkg::*;
    logic [3:0]     nibble [2];  // raw map nibble, index 0 = physical port 1
    logic           map_en;      // remap enable
    hpcfg_lnum_type lnum   [2];  // effective logical number, 0 = disabled
    modport regs (output nibble, output map_en, input lnum);
    modport dec  (input nibble, input map_en, output lnum);
endinterface

// >>> verilog/hpcfg_map_decode.sv
module hpcfg_map_decode
(
    hpcfg_map_if.dec mp  // raw nibbles in, logical numbers out
);
    import hpcfg_pkg::*;

    // nibble to logical number, reserved codes disable
    function automatic hpcfg_lnum_type decode_nibble(input logic [3:0] nib);
        if (nib > MAP_MAX_CODE)
            decode_nibble = LOGIC_OFF;
        else
            decode_nibble = nib[1:0];
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_port
            // physical numbering when remap is off
            assign mp.lnum[gi] = mp.map_en
                ? decode_nibble(mp.nibble[gi])
                : hpcfg_lnum_type'(gi + 1);
        end
    endgenerate
endmodule

// >>> verilog/hpcfg_regs.sv
module hpcfg_regs
(
    input  wire logic                   core_clk,       // core clock 25 MHz
    input  wire logic                   resetn,         // sync reset, low
    input  wire logic                   cfg_wr,         // register write strobe
    input  wire logic                   cfg_rd,         // register read strobe
    input  wire logic [7:0]             cfg_addr,       // register offset
    input  wire logic [7:0]             cfg_wdata,      // write data
    output logic [7:0]                  cfg_rdata,      // read data
    input  wire logic                   logical_map_enable, // remap enable
    output hpcfg_pkg::hpcfg_boost_type  port1_drive_boost_code, // port 1
    output hpcfg_pkg::hpcfg_boost_type  port2_drive_boost_code, // port 2
    output logic [3:1]                  line_pair_swap_out, // per port
    output hpcfg_pkg::hpcfg_lnum_type   phys1_logical_num, // 0 = off
    output hpcfg_pkg::hpcfg_lnum_type   phys2_logical_num, // 0 = off
    output logic [1:0]                  enabled_port_count // ports 1 and 2
);
    import hpcfg_pkg::*;

    logic [7:0]     boost_ff;
    logic [7:0]     swap_ff;
    logic [7:0]     map_ff;
    logic [7:0]     rdata_ff;
    hpcfg_boost_type boost1_ff;
    hpcfg_boost_type boost2_ff;
    logic [3:1]     swap_out_ff;
    hpcfg_lnum_type lnum1_ff;
    hpcfg_lnum_type lnum2_ff;
    logic [1:0]     count_ff;
    logic [7:0]     nxt_rdata;
    logic [1:0]     nxt_count;

    hpcfg_map_if map_bus ();

    ////////////////////////////////////////////////////////////////////////
    // register storage

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            boost_ff <= BOOST_RST;
        else if (cfg_wr && cfg_addr == BOOST_OFS)
            boost_ff <= cfg_wdata & BOOST_MASK;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            swap_ff <= SWAP_RST;
        else if (cfg_wr && cfg_addr == SWAP_OFS)
            swap_ff <= cfg_wdata & SWAP_MASK;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            map_ff <= MAP_RST;
        else if (cfg_wr && cfg_addr == MAP_OFS)
            map_ff <= cfg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, unmapped offsets read zero

    always_comb
    begin
        case (cfg_addr)
            BOOST_OFS: nxt_rdata = boost_ff;
            SWAP_OFS:  nxt_rdata = swap_ff;
            MAP_OFS:   nxt_rdata = map_ff;
            default:   nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            rdata_ff <= RDATA_RST;
        else if (cfg_rd)
            rdata_ff <= nxt_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // transceiver settings

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            boost1_ff <= BOOST_RST[2:0];
            boost2_ff <= BOOST_RST[2:0];
        end
        else
        begin
            boost1_ff <= boost_ff[BOOST1_LSB +: 3];
            boost2_ff <= boost_ff[BOOST2_LSB +: 3];
        end
    end

    // 1 means D+ is driven on DM and D- on DP
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            swap_out_ff <= SWAP_RST[3:1];
        else
            swap_out_ff <= swap_ff[SWAP_LSB +: 3];
    end

    ////////////////////////////////////////////////////////////////////////
    // port numbering

    assign map_bus.nibble[0] = map_ff[MAP1_LSB +: 4];
    assign map_bus.nibble[1] = map_ff[MAP2_LSB +: 4];
    assign map_bus.map_en    = logical_map_enable;

    hpcfg_map_decode u_map_decode
    (
        .mp (map_bus.dec)
    );

    always_comb
    begin
        nxt_count = 2'(map_bus.lnum[0] != LOGIC_OFF)
                  + 2'(map_bus.lnum[1] != LOGIC_OFF);
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            lnum1_ff <= LNUM1_RST;
            lnum2_ff <= LNUM2_RST;
            count_ff <= COUNT_RST;
        end
        else
        begin
            lnum1_ff <= map_bus.lnum[0];
            lnum2_ff <= map_bus.lnum[1];
            count_ff <= nxt_count;
        end
    end

    assign cfg_rdata              = rdata_ff;
    assign port1_drive_boost_code = boost1_ff;
    assign port2_drive_boost_code = boost2_ff;
    assign line_pair_swap_out     = swap_out_ff;
    assign phys1_logical_num      = lnum1_ff;
    assign phys2_logical_num      = lnum2_ff;
    assign enabled_port_count     = count_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    boost2_field_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        cfg_wr && cfg_addr == BOOST_OFS ##1 !cfg_wr [*1]
        |=> port2_drive_boost_code == $past(cfg_wdata[6:4], 2))
        else $error("port 2 boost code does not follow bits 6:4");

    boost1_field_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        cfg_wr && cfg_addr == BOOST_OFS
        |=> ##1 port1_drive_boost_code == $past(cfg_wdata[2:0], 2))
        else $error("port 1 boost code does not follow bits 2:0");

    reset_values_a: assert property (
        @(posedge core_clk)
        !resetn ##1 resetn |-> boost_ff == 8'h00 && swap_ff == 8'h00
            && port1_drive_boost_code == 3'h0
            && line_pair_swap_out == 3'h0)
        else $error("boost or swap not zero after reset");

    swap_bits_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        cfg_wr && cfg_addr == SWAP_OFS
        |=> ##1 line_pair_swap_out == $past(cfg_wdata[3:1], 2))
        else $error("swap outputs do not follow bits 3:1");

    swap_reserved_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        cfg_rd && cfg_addr == SWAP_OFS
        |=> cfg_rdata[0] == 1'b0 && cfg_rdata[7:4] == 4'h0)
        else $error("reserved swap bit reads nonzero");

    map_reset_a: assert property (
        @(posedge core_clk)
        !resetn |=> map_ff == 8'h21)
        else $error("mapping register not 0x21 after reset");

    map_port2_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        logical_map_enable && map_ff[7:4] <= 4'h3
        |=> phys2_logical_num == $past(map_ff[5:4]))
        else $error("physical port 2 number wrong");

    map_port1_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        logical_map_enable && map_ff[3:0] <= 4'h3
        |=> phys1_logical_num == $past(map_ff[1:0]))
        else $error("physical port 1 number wrong");

    map_off_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !logical_map_enable [*2]
        |-> phys1_logical_num == 2'h1 && phys2_logical_num == 2'h2)
        else $error("numbering not physical with remap off");

    map_reserved_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        logical_map_enable && map_ff[7:4] > 4'h3
        |=> phys2_logical_num == 2'h0)
        else $error("reserved code did not disable port 2");

    port_count_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $past(resetn) |-> enabled_port_count ==
            2'(phys1_logical_num != 2'h0) + 2'(phys2_logical_num != 2'h0))
        else $error("enabled port count wrong");

    read_zero_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        cfg_rd && cfg_addr == BOOST_OFS
        |=> cfg_rdata[7] == 1'b0 && cfg_rdata[3] == 1'b0)
        else $error("reserved boost bit reads nonzero");
endmodule

// >>> sim/hpcfg_regs_test.sv
module hpcfg_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import hpcfg_pkg::*;

    logic            core_clk;
    logic            resetn;
    logic            cfg_wr;
    logic            cfg_rd;
    logic [7:0]      cfg_addr;
    logic [7:0]      cfg_wdata;
    logic [7:0]      cfg_rdata;
    logic            en;
    hpcfg_boost_type b1;
    hpcfg_boost_type b2;
    logic [3:1]      swp;
    hpcfg_lnum_type  p1;
    hpcfg_lnum_type  p2;
    logic [1:0]      cnt;
    logic [7:0]      mb;
    logic [7:0]      ms;
    logic [7:0]      mm;
    logic [7:0]      d;
    int              num_errors;
    int              n_checks;
    int              cycles;

    hpcfg_regs i_dut
    (
        .core_clk               (core_clk),
        .resetn                 (resetn),
        .cfg_wr                 (cfg_wr),
        .cfg_rd                 (cfg_rd),
        .cfg_addr               (cfg_addr),
        .cfg_wdata              (cfg_wdata),
        .cfg_rdata              (cfg_rdata),
        .logical_map_enable     (en),
        .port1_drive_boost_code (b1),
        .port2_drive_boost_code (b2),
        .line_pair_swap_out     (swp),
        .phys1_logical_num      (p1),
        .phys2_logical_num      (p2),
        .enabled_port_count     (cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string w, input logic [7:0] s, e);
        n_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", w, e, s);
        end
    endtask

    // effective logical number of one physical port
    function automatic logic [1:0] lnum(input logic [3:0] c, input logic e,
                                        input logic [1:0] n);
        if (!e)
            return n;
        return (c <= 4'h3) ? c[1:0] : 2'h0;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        #1;
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = v;
        @(posedge core_clk);
        #1;
        cfg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        #1;
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(posedge core_clk);
        #1;
        cfg_rd = 1'b0;
        v = cfg_rdata;
    endtask

    task automatic check_all;
        logic [1:0] e1;
        logic [1:0] e2;
        logic [1:0] ec;
        repeat (2) @(posedge core_clk);
        #1;
        e1 = lnum(mm[3:0], en, 2'h1);
        e2 = lnum(mm[7:4], en, 2'h2);
        ec = 2'(e1 != 0) + 2'(e2 != 0);
        chk("port1 boost", {5'h00, b1}, {5'h00, mb[2:0]});
        chk("port2 boost", {5'h00, b2}, {5'h00, mb[6:4]});
        chk("swap", {5'h00, swp}, {5'h00, ms[3:1]});
        chk("phys1", {6'h00, p1}, {6'h00, e1});
        chk("phys2", {6'h00, p2}, {6'h00, e2});
        chk("count", {6'h00, cnt}, {6'h00, ec});
        rd(8'hF8, d);
        chk("boost reg", d, mb & 8'h77);
        rd(8'hFA, d);
        chk("swap reg", d, ms & 8'h0E);
        rd(8'hFB, d);
        chk("map reg", d, mm);
        rd(8'hF9, d);
        chk("unmapped", d, 8'h00);
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] v);
        wr(a, v);
        if (a == 8'hF8)
            mb = v;
        if (a == 8'hFA)
            ms = v;
        if (a == 8'hFB)
            mm = v;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    initial
    begin
        logic [7:0] tbl [6];
        tbl = '{8'hF8, 8'hFA, 8'hFB, 8'hF9, 8'hFC, 8'h00};
        num_errors = 0;
        n_checks = 0;
        cycles = 0;
        resetn = 1'b0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        en = 1'b0;
        mb = 8'h00;
        ms = 8'h00;
        mm = 8'h21;
        void'($urandom(15248));
        repeat (16) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        check_all();
        repeat (60)
        begin
            put(tbl[$urandom_range(0, 5)], 8'($urandom));
            en = 1'($urandom);
            check_all();
        end
        // every nibble pair, map off and on
        for (int e = 0; e < 2; e++)
            for (int i = 0; i < 256; i++)
            begin
                en = 1'(e);
                put(8'hFB, 8'(i));
                check_all();
            end
        // contiguous numbering as software must program it
        put(8'hFB, 8'h12);
        check_all();
        put(8'hFB, 8'h01);
        check_all();
        put(8'hF8, 8'hFF);
        put(8'hFA, 8'hFF);
        // read and write same cycle, then back to back writes
        @(posedge core_clk);
        #1;
        cfg_wr = 1'b1;
        cfg_rd = 1'b1;
        cfg_addr = 8'hF8;
        cfg_wdata = 8'h51;
        @(posedge core_clk);
        #1;
        cfg_rd = 1'b0;
        chk("old on rd+wr", cfg_rdata, 8'h77);
        cfg_addr = 8'hFA;
        cfg_wdata = 8'h04;
        @(posedge core_clk);
        #1;
        cfg_wr = 1'b0;
        mb = 8'h51;
        ms = 8'h04;
        check_all();
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        mb = 8'h00;
        ms = 8'h00;
        mm = 8'h21;
        chk("rdata rst", cfg_rdata, 8'h00);
        check_all();
        wrap_up();
    end
endmodule
